//--- hw/pscr_defs.vh
// Constants for the PHY-specific configuration register block
`ifndef PSCR_DEFS_VH
`define PSCR_DEFS_VH
// APB byte address of the register (printed offset 0x10, word aligned)
`define PSCR_ADDR_CFG 8'h10
`define PSCR_ADDR_STATUS 8'h14
`define PSCR_ADDR_W 8
// Field positions of the configuration register
`define PSCR_BIT_CODING_BYPASS 15
`define PSCR_BIT_SCRAMBLER_BYPASS 14
`define PSCR_BIT_ALIGNMENT_BYPASS 13
`define PSCR_BIT_SIGNAL_DETECT_FORCE 12
`define PSCR_BIT_RSVD11 11
`define PSCR_BIT_TX_MODE 10
`define PSCR_BIT_RSVD9 9
`define PSCR_BIT_RSVD8 8
`define PSCR_BIT_FORCE_LINK 7
`define PSCR_BIT_LED_A 6
`define PSCR_BIT_LED_B 5
`define PSCR_BIT_AUTO_RPD 4
`define PSCR_BIT_SM_RESET 3
`define PSCR_BIT_PREAMBLE 2
`define PSCR_BIT_SLEEP 1
`define PSCR_BIT_LOOPOUT 0
// Reset value: tx mode, auto reduced power and preamble suppress set
`define PSCR_CFG_RESET 16'h0414
// Writable bit mask (bit 9 and bit 3 storage excluded)
`define PSCR_CFG_WMASK 16'hfdf7
// State machine reset pulse length in clock cycles
`define PSCR_STATE_MACHINE_RESET_CYCLES 4'h8
`define PSCR_CNT_ZERO 4'h0
`define PSCR_CNT_ONE 4'h1
`endif

//--- hw/pscr_sm_reset.v
// Self-clearing state machine reset sequencer
`timescale 1ns/100ps
`default_nettype none
module pscr_sm_reset (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Control
  input wire start,
  // Status
  output reg busy,
  output reg sm_reset
);
`include "pscr_defs.vh"

  reg [3:0] count;

  // Hold the reset for a fixed number of cycles, restart on new request
  always @(posedge clock) begin
    if (sys_rst) begin
      count <= `PSCR_CNT_ZERO;
      busy <= 1'b0;
      sm_reset <= 1'b0;
    end else if (start) begin
      count <= `PSCR_STATE_MACHINE_RESET_CYCLES;
      busy <= 1'b1;
      sm_reset <= 1'b1;
    end else if (count != `PSCR_CNT_ZERO) begin
      count <= count - `PSCR_CNT_ONE;
      busy <= (count != `PSCR_CNT_ONE);
      sm_reset <= (count != `PSCR_CNT_ONE);
    end
  end
endmodule // pscr_sm_reset
`default_nettype wire

//--- hw/pscr_top.v
// PHY-specific configuration register with APB access
// Function
// RQ1: Coding bypass set skips 4B5B encode and 5B4B decode; resets 0.
// RQ2: Scrambler bypass set skips scrambler and descrambler; resets 0.
// RQ3: Alignment bypass skips descrambler, alignment, decode, encode, scrambler; resets 0.
// RQ4: Signal detect force makes detector report valid signal; resets 0.
// RQ5: Software writes 0 to reserved bits 11, 8, 6, 5; they reset 0.
// RQ6: Tx mode bit resets 1; while set, operate in 100BASE-TX.
// RQ7: Force link reports good 100 Mbps link regardless of line; resets 0.
// RQ8: Auto reduced power enable resets 1; set enables automatic reduced power.
// RQ9: Writing 1 resets all state machines; bit clears itself afterwards.
// RQ10: Preamble suppress bit resets 1; set turns suppression on.
// RQ11: Writing 1 to sleep powers down all but clocking; resets 0.
// RQ12: Waking keeps configuration but resets the state machines.
// RQ13: Remote loopout routes received data back to transmit; resets 0.
// RQ14: Bit 9 always reads 0; writes to it do nothing.
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module pscr_top (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Line status from the PHY datapath (asynchronous)
  input wire signal_detect_raw,
  input wire link_100_raw,
  // Datapath controls
  output reg coding_bypass_en,
  output reg scrambler_bypass_en,
  output reg descrambler_bypass_en,
  output reg align_bypass_en,
  output reg encoder_bypass_en,
  output reg decoder_bypass_en,
  output reg signal_detect,
  output reg tx_mode_100,
  output reg link_100_good,
  output reg auto_rpd_en,
  output reg mgmt_preamble_suppress,
  output reg sleep_powerdown,
  output reg remote_loopout,
  output reg sm_reset
);
`include "pscr_defs.vh"

  ////////////////////////////////////////////////////////////////////
  // Storage and synchronisers
  reg [15:0] cfg;
  reg sd_meta;
  reg sd_sync;
  reg link_meta;
  reg link_sync;
  wire sm_busy;
  wire sm_pulse;
  reg start_sm;
  wire [`PSCR_ADDR_W-1:0] addr = paddr[`PSCR_ADDR_W-1:0];
  wire addr_hi_zero = (paddr[31:`PSCR_ADDR_W] == 24'h000000);
  wire hit_cfg = addr_hi_zero && (addr == `PSCR_ADDR_CFG);
  wire hit_status = addr_hi_zero && (addr == `PSCR_ADDR_STATUS);
  wire setup = psel && !penable;
  wire wr_cfg = setup && pwrite && hit_cfg;
  wire [15:0] wdata = pwdata[15:0];
  wire [15:0] cfg_view;
  wire [15:0] next_cfg;

  // Line inputs pass two flops before use
  always @(posedge clock) begin
    if (sys_rst) begin
      sd_meta <= 1'b0;
      sd_sync <= 1'b0;
      link_meta <= 1'b0;
      link_sync <= 1'b0;
    end else begin
      sd_meta <= signal_detect_raw;
      sd_sync <= sd_meta;
      link_meta <= link_100_raw;
      link_sync <= link_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register write, one cycle answer (taken at setup edge)
  assign next_cfg = (cfg & ~`PSCR_CFG_WMASK) | (wdata & `PSCR_CFG_WMASK); // see RQ14

  always @(posedge clock) begin
    if (sys_rst) begin
      cfg <= `PSCR_CFG_RESET; // see RQ6 // see RQ8 // see RQ10
    end else if (wr_cfg) begin
      // Reserved bits stored as written, software keeps them 0; see RQ5
      cfg <= next_cfg;
    end
  end

  // Start the state machine reset on a 1 write or on leaving sleep
  always @(posedge clock) begin
    if (sys_rst) begin
      start_sm <= 1'b0;
    end else begin
      start_sm <= wr_cfg && (wdata[`PSCR_BIT_SM_RESET] || // see RQ9
        (cfg[`PSCR_BIT_SLEEP] && !wdata[`PSCR_BIT_SLEEP])); // see RQ12
    end
  end

  // Reset sequencer
  pscr_sm_reset u_state_machine_reset (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(start_sm),
    .busy(sm_busy),
    .sm_reset(sm_pulse)
  );

  // Read view: reset bit shows 1 until the sequence is done, bit 9 zero
  assign cfg_view = {cfg[15:`PSCR_BIT_SM_RESET+1], (sm_busy | start_sm), // see RQ9
    cfg[`PSCR_BIT_SM_RESET-1:0]};

  ////////////////////////////////////////////////////////////////////
  // APB answer: ready in the access cycle, error on unmapped address or on a write to the status word
  always @(posedge clock) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && !(hit_cfg || (hit_status && !pwrite));
      if (setup && !pwrite && hit_cfg) begin
        prdata <= {16'h0000, cfg_view};
      end else if (setup && !pwrite && hit_status) begin
        prdata <= {28'h0000000, sleep_powerdown, link_100_good, signal_detect, sm_reset};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Datapath controls, all registered
  always @(posedge clock) begin
    if (sys_rst) begin
      coding_bypass_en <= 1'b0;
      scrambler_bypass_en <= 1'b0;
      descrambler_bypass_en <= 1'b0;
      align_bypass_en <= 1'b0;
      encoder_bypass_en <= 1'b0;
      decoder_bypass_en <= 1'b0;
      signal_detect <= 1'b0;
      tx_mode_100 <= 1'b1;
      link_100_good <= 1'b0;
      auto_rpd_en <= 1'b1;
      mgmt_preamble_suppress <= 1'b1;
      sleep_powerdown <= 1'b0;
      remote_loopout <= 1'b0;
      sm_reset <= 1'b0;
    end else begin
      coding_bypass_en <= cfg[`PSCR_BIT_CODING_BYPASS]; // see RQ1
      encoder_bypass_en <= cfg[`PSCR_BIT_CODING_BYPASS] | cfg[`PSCR_BIT_ALIGNMENT_BYPASS]; // see RQ1 // see RQ3
      decoder_bypass_en <= cfg[`PSCR_BIT_CODING_BYPASS] | cfg[`PSCR_BIT_ALIGNMENT_BYPASS]; // see RQ1 // see RQ3
      scrambler_bypass_en <= cfg[`PSCR_BIT_SCRAMBLER_BYPASS] | cfg[`PSCR_BIT_ALIGNMENT_BYPASS]; // see RQ2 // see RQ3
      descrambler_bypass_en <= cfg[`PSCR_BIT_SCRAMBLER_BYPASS] | cfg[`PSCR_BIT_ALIGNMENT_BYPASS]; // see RQ2
      align_bypass_en <= cfg[`PSCR_BIT_ALIGNMENT_BYPASS]; // see RQ3
      signal_detect <= sd_sync | cfg[`PSCR_BIT_SIGNAL_DETECT_FORCE]; // see RQ4
      tx_mode_100 <= cfg[`PSCR_BIT_TX_MODE]; // see RQ6
      link_100_good <= link_sync | cfg[`PSCR_BIT_FORCE_LINK]; // see RQ7
      auto_rpd_en <= cfg[`PSCR_BIT_AUTO_RPD]; // see RQ8
      mgmt_preamble_suppress <= cfg[`PSCR_BIT_PREAMBLE]; // see RQ10
      sleep_powerdown <= cfg[`PSCR_BIT_SLEEP]; // see RQ11
      remote_loopout <= cfg[`PSCR_BIT_LOOPOUT]; // see RQ13
      sm_reset <= sm_pulse; // see RQ9
    end
  end
endmodule // pscr_top
`default_nettype wire

//--- test/pscr_assertions.sv
// Port-level checker for the configuration register block
`timescale 1ns/100ps
`default_nettype none
module pscr_chk (
  // Clock, reset and bus
  input wire logic clock, sys_rst, pwrite, pready, pslverr,
  input wire logic [31:0] paddr, pwdata, prdata,
  // Controls
  input wire logic coding_bypass_en, scrambler_bypass_en, link_100_good, tx_mode_100, sm_reset, sleep_powerdown
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Accepted write to the configuration word
  wire logic wr = pready && pwrite && !pslverr && paddr == 32'h10;
  a_coding_follow: assert property (wr |=> coding_bypass_en == $past(pwdata[15])) else $error("coding bypass");
  a_scram_follow: assert property (wr |=> scrambler_bypass_en == ($past(pwdata[14]) | $past(pwdata[13])))
    else $error("scrambler bypass");
  a_link_force: assert property (wr && pwdata[7] |=> link_100_good) else $error("forced link");
  a_txmode_follow: assert property (wr |=> tx_mode_100 == $past(pwdata[10])) else $error("tx mode");
  a_state_machine_reset_start: assert property (wr && pwdata[3] && !sm_reset |=> ##[0:2] sm_reset) else $error("no sm reset");
  a_state_machine_reset_len: assert property ($rose(sm_reset) |-> sm_reset[*8] ##1 !sm_reset) else $error("sm reset length");
  a_wake_reset: assert property ($fell(sleep_powerdown) |-> ##[0:2] sm_reset) else $error("wake no reset");
  a_bit9_zero: assert property (pready && !pwrite && paddr == 32'h10 |-> !prdata[9]) else $error("bit 9 set");
  // Main scenarios reached
  c_write: cover property (wr);
  c_state_machine_reset: cover property ($rose(sm_reset));
  c_error: cover property (pready && pslverr);
endmodule // pscr_chk
bind pscr_top pscr_chk u_chk (.*);
`default_nettype wire

//--- test/test_pscr_top.sv
// Self-checking bench for the configuration register block
`timescale 1ns/100ps
`default_nettype none
module test_pscr_top;
  logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, e;
  logic [31:0] paddr = 0, pwdata = 0, r;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, cb, sb, db, ab, eb, xb, sd, tx, lk, rpd, mp, sl, lo, sm;
  int failures = 0, num_checks = 0, cyc = 0, n;
  // Observed controls: tx, rpd, preamble, coding, align, detect, link, sleep, loopout
  wire logic [8:0] ctl = {tx, rpd, mp, cb, ab, sd, lk, sl, lo};
  pscr_top dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .signal_detect_raw(1'b0), .link_100_raw(1'b0), .coding_bypass_en(cb), .scrambler_bypass_en(sb),
    .descrambler_bypass_en(db), .align_bypass_en(ab), .encoder_bypass_en(eb), .decoder_bypass_en(xb),
    .signal_detect(sd), .tx_mode_100(tx), .link_100_good(lk), .auto_rpd_en(rpd),
    .mgmt_preamble_suppress(mp), .sleep_powerdown(sl), .remote_loopout(lo), .sm_reset(sm));
  // Clock and hang guard
  initial forever #50 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  // One APB transfer, waiting for pready
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clock);
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset values at the ports and in the register
  task automatic t_reset();
    chk(ctl, 9'h1c0, "reset controls");
    apb(0, 32'h10, 0); chk(r, 32'h414, "reset word");
  endtask
  // Ones except reserved bits 11, 8, 6, 5: read-only bit 9 stays 0, self-clearing bit drops
  task automatic t_all();
    apb(1, 32'hffffffff, 32'hffffffff); chk(e, 1, "unmapped write");
    apb(1, 32'h10, 32'hfffff69f); repeat (12) @(posedge clock);
    apb(0, 32'h10, 0); chk(r, 32'hf497, "ones readback");
    apb(0, 32'h14, 0); chk(r, 32'he, "status view");
    chk(ctl, 9'h1ff, "all controls on");
    chk({sb, db, eb, xb}, 4'hf, "bypass set");
  endtask
  // Wake from sleep keeps configuration and resets state machines
  task automatic t_wake();
    apb(1, 32'h10, 32'h8402); apb(1, 32'h10, 32'h8400);
    n = 0;
    while (sm !== 1'b1 && n < 4) begin @(posedge clock); n++; end
    chk(sm, 1, "wake reset");
    repeat (12) @(posedge clock);
    apb(0, 32'h10, 0); chk(r, 32'h8400, "kept config");
  endtask
  // State machine reset pulse, a refused status write, then self-clear
  task automatic t_state_machine_reset();
    apb(1, 32'h10, 32'h0008); n = 0;
    repeat (12) begin @(posedge clock); n += (sm === 1'b1); end
    chk(n, 8, "reset length");
    apb(1, 32'h14, 32'h1); chk(e, 1, "status write refused");
    apb(0, 32'h10, 0); chk(r, 0, "self cleared");
    chk(ctl, 9'h000, "all off");
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    t_reset(); t_all(); t_wake(); t_state_machine_reset();
    report_and_stop();
  end
endmodule // test_pscr_top
`default_nettype wire
